// file: logic/tlic_core.sv
// Purpose: Two-level interrupt controller with six sources and a Wishbone slave.
// Assumes: Core pulses callTaken once per vector call and retiPulse per return.
// Notes:   Register bytes sit in bit 7:0; upper bits read as zero.
//
// Functional notes
// R1 - six sources, each individually enabled by software
// R2 - each source assigned high or low priority
// R3 - display busy requests on entering blanking
// R4 - one configuration bit picks line or field
// R5 - line mode fires at each active line blank
// R6 - field mode fires at vertical blanking start
// R7 - per-source enables; global bit seven blocks all
// R8 - low routine preempted only by high
// R9 - high routine preempted by nothing
// R10 - simultaneous mixed levels: high served first
// R11 - equal level: fixed polling order decides
// R12 - acknowledged request calls its fixed vector
// R13 - type bit zero: external input active low
// R14 - type one: falling edge, or both edges
// R15 - edges latched until call; levels follow pin
// R16 - track in-service levels, release on return
`timescale 1ns/100ps

module tlic_core
    import tlic_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 srst,
    // Wishbone slave
    input  wire logic                 wbCyc,
    input  wire logic                 wbStb,
    input  wire logic                 wbWe,
    input  wire logic [WB_AW-1:0]     wbAdr,
    input  wire logic [3:0]           wbSel,
    input  wire logic [WB_DW-1:0]     wbDatI,
    output logic      [WB_DW-1:0]     wbDatO,
    output logic                      wbAck,
    // Request sources
    input  wire logic                 extReqPinZero,
    input  wire logic                 extReqPinOne,
    input  wire logic                 timerZeroOvf,
    input  wire logic                 timerOneOvf,
    input  wire logic                 serialReq,
    input  wire logic                 hBlank,
    input  wire logic                 vBlank,
    input  wire logic                 lineActive,
    // Processor core
    input  wire logic                 callTaken,
    input  wire logic                 retiPulse,
    output logic                      vecReq,
    output logic      [VEC_W-1:0]     vecAddr,
    output logic                      vecHighLevel,
    // Event interrupt
    output logic                      irqOut
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [REG_W-1:0]   irqEnable;
        logic [REG_W-1:0]   irqPriority;
        logic [REG_W-1:0]   timerControl;
        logic               busyLineOrFieldSel;
        logic [NUM_SRC-1:0] evtStatus;
        logic [NUM_SRC-1:0] evtEnable;
        logic [NUM_SRC-1:0] reqPrev;
        logic               extZeroPrev;
        logic               extOnePrev;
        logic               hBlankPrev;
        logic               vBlankPrev;
        logic               vecReq;
        logic [VEC_W-1:0]   vecAddr;
        logic [SRC_IW-1:0]  vecSrc;
        logic               vecHigh;
        logic               inSvcHigh;
        logic               inSvcLow;
        logic               ack;
        logic [WB_DW-1:0]   rdat;
        logic               irq;
    } tlic_state_t;

    tlic_state_t st_q;
    tlic_state_t st_d;

    logic [NUM_SRC-1:0] srcLevelMode;
    logic [NUM_SRC-1:0] srcLevelReq;
    logic [NUM_SRC-1:0] srcEvent;
    logic [NUM_SRC-1:0] srcClear;
    logic [NUM_SRC-1:0] srcReq;
    logic [NUM_SRC-1:0] enabledReq;
    logic [NUM_SRC-1:0] highReq;
    logic [NUM_SRC-1:0] lowReq;
    logic               highValid;
    logic               lowValid;
    logic [SRC_IW-1:0]  highIdx;
    logic [SRC_IW-1:0]  lowIdx;
    logic               ext0Type;
    logic               ext1Type;
    logic               busyEvent;
    logic               callDone;

    assign ext0Type = st_q.timerControl[EXT0_TYPE_BIT];
    assign ext1Type = st_q.timerControl[EXT1_TYPE_BIT];
    assign callDone = st_q.vecReq & callTaken;

    // ****************************************************************
    // Source conditioning
    // ****************************************************************
    always_comb
    begin
        // R13 - active low external levels; serial level active high
        srcLevelMode             = '0;
        srcLevelReq              = '0;
        srcLevelMode[SRC_EXT0]   = ~ext0Type;
        srcLevelReq[SRC_EXT0]    = ~extReqPinZero;
        srcLevelMode[SRC_EXT1]   = ~ext1Type;
        srcLevelReq[SRC_EXT1]    = ~extReqPinOne;
        srcLevelMode[SRC_SERIAL] = 1'b1;
        srcLevelReq[SRC_SERIAL]  = serialReq;
    end

    always_comb
    begin
        // R5 R6 - blanking entry
        if (st_q.busyLineOrFieldSel)
        begin
            busyEvent = hBlank & ~st_q.hBlankPrev & lineActive;
        end
        else
        begin
            busyEvent = vBlank & ~st_q.vBlankPrev;
        end
    end

    always_comb
    begin
        // R14 - edge detection
        srcEvent             = '0;
        srcEvent[SRC_EXT0]   = ext0Type & st_q.extZeroPrev & ~extReqPinZero;
        srcEvent[SRC_EXT1]   = ext1Type & (st_q.extOnePrev ^ extReqPinOne);
        srcEvent[SRC_TIMER0] = timerZeroOvf;
        srcEvent[SRC_TIMER1] = timerOneOvf;
        // R3 - busy on blanking
        srcEvent[SRC_BUSY]   = busyEvent;
    end

    always_comb
    begin
        // R15 - clear on call
        srcClear = '0;
        if (callDone)
        begin
            srcClear[st_q.vecSrc] = 1'b1;
        end
    end

    // R15 - latched edges, level pins
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_src
            tlic_src_cond u_cond (
                .clock      (clock),
                .srst       (srst),
                .levelMode  (srcLevelMode[g]),
                .levelReq   (srcLevelReq[g]),
                .eventPulse (srcEvent[g]),
                .takeClear  (srcClear[g]),
                .request    (srcReq[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    // R1 R7 - enables and global gate
    assign enabledReq = srcReq & st_q.irqEnable[NUM_SRC-1:0]
                      & {NUM_SRC{st_q.irqEnable[GLOBAL_EN_BIT]}};
    // R2 - level split
    assign highReq    = enabledReq & st_q.irqPriority[NUM_SRC-1:0];
    assign lowReq     = enabledReq & ~st_q.irqPriority[NUM_SRC-1:0];

    // R11 - polling order
    tlic_prio_pick #(.N(NUM_SRC), .IW(SRC_IW)) u_pick_high (
        .req   (highReq),
        .valid (highValid),
        .idx   (highIdx)
    );

    tlic_prio_pick #(.N(NUM_SRC), .IW(SRC_IW)) u_pick_low (
        .req   (lowReq),
        .valid (lowValid),
        .idx   (lowIdx)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic               access;
        logic               wrLane;
        logic [NUM_SRC-1:0] clrMask;
        logic [NUM_SRC-1:0] reqRise;
        access  = wbCyc & wbStb & ~st_q.ack;
        wrLane  = access & wbWe & wbSel[0];
        clrMask = '0;
        reqRise = srcReq & ~st_q.reqPrev;
        st_d    = st_q;

        st_d.extZeroPrev = extReqPinZero;
        st_d.extOnePrev  = extReqPinOne;
        st_d.hBlankPrev  = hBlank;
        st_d.vBlankPrev  = vBlank;
        st_d.reqPrev     = srcReq;

        // Register writes.
        if (wrLane)
        begin
            case (wbAdr)
                ADDR_IRQ_ENABLE: st_d.irqEnable    = wbDatI[REG_W-1:0];
                ADDR_IRQ_PRIO:   st_d.irqPriority  = wbDatI[REG_W-1:0];
                ADDR_TIMER_CTRL: st_d.timerControl = wbDatI[REG_W-1:0];
                ADDR_EVT_CLEAR:  clrMask           = wbDatI[NUM_SRC-1:0];
                ADDR_EVT_ENABLE: st_d.evtEnable    = wbDatI[NUM_SRC-1:0];
                // R4 - mode select bit
                ADDR_DISP_CFG:   st_d.busyLineOrFieldSel = wbDatI[LINE_SEL_BIT];
                default:         st_d.irqEnable    = st_q.irqEnable;
            endcase
        end

        // A new request edge wins over a clear in the same cycle.
        st_d.evtStatus = (st_q.evtStatus & ~clrMask) | reqRise;

        // Register reads; unmapped addresses answer zero.
        st_d.ack  = access;
        st_d.rdat = RST_WORD;
        if (access && !wbWe)
        begin
            case (wbAdr)
                ADDR_IRQ_ENABLE: st_d.rdat[REG_W-1:0]   = st_q.irqEnable;
                ADDR_IRQ_PRIO:   st_d.rdat[REG_W-1:0]   = st_q.irqPriority;
                ADDR_TIMER_CTRL: st_d.rdat[REG_W-1:0]   = st_q.timerControl;
                ADDR_EVT_STATUS: st_d.rdat[NUM_SRC-1:0] = st_q.evtStatus;
                ADDR_EVT_ENABLE: st_d.rdat[NUM_SRC-1:0] = st_q.evtEnable;
                ADDR_IN_SERVICE:
                begin
                    st_d.rdat[INSVC_LOW_BIT] = st_q.inSvcLow;
                    st_d.rdat[INSVC_HI_BIT]  = st_q.inSvcHigh;
                end
                ADDR_DISP_CFG:   st_d.rdat[LINE_SEL_BIT] = st_q.busyLineOrFieldSel;
                default:         st_d.rdat = RST_WORD;
            endcase
        end

        // R16 - release on return
        if (retiPulse)
        begin
            if (st_q.inSvcHigh)
            begin
                st_d.inSvcHigh = 1'b0;
            end
            else
            begin
                st_d.inSvcLow = 1'b0;
            end
        end

        if (st_q.vecReq)
        begin
            if (callTaken)
            begin
                // R16 - mark level busy
                st_d.vecReq = 1'b0;
                if (st_q.vecHigh)
                begin
                    st_d.inSvcHigh = 1'b1;
                end
                else
                begin
                    st_d.inSvcLow = 1'b1;
                end
            end
            else if (!enabledReq[st_q.vecSrc])
            begin
                // A withdrawn level or a cleared enable cancels the offer.
                st_d.vecReq = 1'b0;
            end
        end
        // R9 R10 - high first, unblocked
        else if (highValid && !st_q.inSvcHigh)
        begin
            st_d.vecReq  = 1'b1;
            st_d.vecSrc  = highIdx;
            st_d.vecHigh = 1'b1;
            // R12 - fixed vector
            st_d.vecAddr = SRC_VECTORS[highIdx];
        end
        // R8 - low waits
        else if (lowValid && !st_q.inSvcHigh && !st_q.inSvcLow)
        begin
            st_d.vecReq  = 1'b1;
            st_d.vecSrc  = lowIdx;
            st_d.vecHigh = 1'b0;
            // R12 - fixed vector
            st_d.vecAddr = SRC_VECTORS[lowIdx];
        end

        st_d.irq = |(st_d.evtStatus & st_d.evtEnable);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_q             <= '0;
            st_q.irqEnable   <= RST_REG8;
            st_q.irqPriority <= RST_REG8;
            st_q.extZeroPrev <= 1'b1;
            st_q.extOnePrev  <= 1'b1;
            st_q.vecAddr     <= RST_VEC;
            st_q.rdat        <= RST_WORD;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign wbDatO       = st_q.rdat;
    assign wbAck        = st_q.ack;
    assign vecReq       = st_q.vecReq;
    assign vecAddr      = st_q.vecAddr;
    assign vecHighLevel = st_q.vecHigh;
    assign irqOut       = st_q.irq;

endmodule

// file: logic/tlic_prio_pick.sv
// Purpose: Fixed-order picker; the lowest set index wins.
// Assumes: Purely combinational, used inside a clocked parent.
// Notes:   Index zero is polled first.
`timescale 1ns/100ps

module tlic_prio_pick #(
    parameter int N  = 6,
    parameter int IW = 3
) (
    // Requests
    input  wire logic [N-1:0]  req,
    // Result
    output logic               valid,
    output logic [IW-1:0]      idx
);

    always_comb
    begin
        valid = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                valid = 1'b1;
                idx   = i[IW-1:0];
            end
        end
    end

endmodule

// file: logic/tlic_src_cond.sv
// Purpose: Conditions one request source as a level or a latched event.
// Assumes: All inputs synchronous to clock.
// Notes:   A set arriving with the clear keeps the flag set.
`timescale 1ns/100ps

module tlic_src_cond
    import tlic_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Source
    input  wire logic levelMode,
    input  wire logic levelReq,
    input  wire logic eventPulse,
    input  wire logic takeClear,
    // Result
    output logic      request
);

    typedef struct packed {
        logic pend;
    } tlic_cond_t;

    tlic_cond_t st_q;
    tlic_cond_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (takeClear)
        begin
            st_d.pend = 1'b0;
        end
        if (eventPulse)
        begin
            st_d.pend = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Level sources follow the pin; a stale latched event is not shown.
    assign request = levelMode ? levelReq : st_q.pend;

endmodule

// file: shared/tlic_pkg.sv
// Purpose: Shared constants for the two-level interrupt controller.
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses.
// Notes:   Registers hold 8-bit values in the low byte of each word.

package tlic_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_SRC  = 6;
    localparam int SRC_IW   = 3;
    localparam int WB_DW    = 32;
    localparam int WB_AW    = 18;
    localparam int REG_W    = 8;
    localparam int VEC_W    = 16;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [WB_AW-1:0] ADDR_IRQ_ENABLE = 18'h00000;
    localparam logic [WB_AW-1:0] ADDR_IRQ_PRIO   = 18'h00004;
    localparam logic [WB_AW-1:0] ADDR_TIMER_CTRL = 18'h00008;
    localparam logic [WB_AW-1:0] ADDR_EVT_STATUS = 18'h0000C;
    localparam logic [WB_AW-1:0] ADDR_EVT_CLEAR  = 18'h00010;
    localparam logic [WB_AW-1:0] ADDR_EVT_ENABLE = 18'h00014;
    localparam logic [WB_AW-1:0] ADDR_IN_SERVICE = 18'h00018;
    localparam logic [15:0]      DMC_INDEX       = 16'h87FF;
    localparam logic [WB_AW-1:0] ADDR_DISP_CFG   = {DMC_INDEX, 2'b00};

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int GLOBAL_EN_BIT = 7;
    localparam int EXT0_TYPE_BIT = 0;
    localparam int EXT1_TYPE_BIT = 2;
    localparam int LINE_SEL_BIT  = 0;
    localparam int INSVC_LOW_BIT = 0;
    localparam int INSVC_HI_BIT  = 1;

    // ****************************************************************
    // Source indices in polling order and their vectors
    // ****************************************************************
    localparam int SRC_EXT0   = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1   = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_SERIAL = 4;
    localparam int SRC_BUSY   = 5;

    localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_VECTORS =
        {16'h0033, 16'h002B, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [REG_W-1:0] RST_REG8  = 8'h00;
    localparam logic [WB_DW-1:0] RST_WORD  = 32'h00000000;
    localparam logic [VEC_W-1:0] RST_VEC   = 16'h0000;

endpackage

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the two-level interrupt controller.
// Assumes: Each routine releases its own source before it returns.
// Notes:   Priority masks and call delays come from an LFSR seeded with 86.
`timescale 1ns/100ps

module testbench
    import tlic_pkg::*;
;
    logic             clock, srst = 1'h1, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0, wbAck;
    logic [WB_AW-1:0] wbAdr = 18'h00000;
    logic [3:0]       wbSel = 4'hF;
    logic [WB_DW-1:0] wbDatI = 32'h00000000, wbDatO;
    logic             extReqPinZero = 1'h1, extReqPinOne = 1'h1, serialReq = 1'h0;
    logic             timerZeroOvf = 1'h0, timerOneOvf = 1'h0, retGo = 1'h0, lvl = 1'h1;
    logic             hBlank = 1'h0, vBlank = 1'h0, lineActive = 1'h0;
    logic             callTaken, retiPulse, vecReq, vecHighLevel, irqOut;
    logic [VEC_W-1:0] vecAddr;
    logic [1:0]       callDelay = 2'h0;
    logic [7:0]       rnd = 8'h56, rd;
    logic [5:0]       pr;
    int               errorCnt = 0, nTests = 0;
    int               expQ[$];
    logic [15:0]      vt[6] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h002B, 16'h0033};
    logic [WB_AW-1:0] regs[7] = '{ADDR_IRQ_ENABLE, ADDR_IRQ_PRIO, ADDR_TIMER_CTRL,
        ADDR_EVT_STATUS, ADDR_EVT_ENABLE, ADDR_IN_SERVICE, ADDR_DISP_CFG};

    tlic_core tlic_core_inst (.clock, .srst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI,
        .wbDatO, .wbAck, .extReqPinZero, .extReqPinOne, .timerZeroOvf, .timerOneOvf,
        .serialReq, .hBlank, .vBlank, .lineActive, .callTaken, .retiPulse, .vecReq,
        .vecAddr, .vecHighLevel, .irqOut);
    tlic_cpu_model tlic_cpu_model_inst (.clock, .srst, .vecReq, .callTaken, .retiPulse,
        .callDelay, .retGo);

    initial
    begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic closeOut();
        if (errorCnt == 0 && nTests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tmo();
        errorCnt++;
        $display("mismatch at %0t: wait timed out", $time);
        closeOut();
    endtask

    task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wbCyc  <= 1'h1;
        wbStb  <= 1'h1;
        wbWe   <= w;
        wbAdr  <= a;
        wbDatI <= {24'h000000, d};
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wbAck !== 1'h1 && n < 20);
        if (n >= 20)
            tmo();
        rd = wbDatO[7:0];
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
    endtask

    task automatic rdChk(input logic [WB_AW-1:0] a, input logic [7:0] e);
        wb(1'h0, a, 8'h00);
        chk(16'(rd), 16'(e));
    endtask

    task automatic fire(input logic [5:0] m);
        @(posedge clock);
        timerZeroOvf <= m[1];
        timerOneOvf  <= m[3];
        vBlank       <= vBlank | m[5];
        // Latched events show a cycle late, so levels follow one edge after them.
        @(posedge clock);
        extReqPinZero <= extReqPinZero & ~m[0];
        extReqPinOne  <= extReqPinOne & ~m[2];
        serialReq     <= serialReq | m[4];
        timerZeroOvf  <= 1'h0;
        timerOneOvf   <= 1'h0;
    endtask

    task automatic ret1();
        @(posedge clock);
        retGo <= 1'h1;
        @(posedge clock);
        retGo <= 1'h0;
    endtask

    task automatic svc(input int i, input logic hi, input bit ret);
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (callTaken !== 1'h1 && n < 60);
        if (n >= 60)
            tmo();
        chk(vecAddr, vt[i]);
        chk(16'(vecHighLevel), 16'(hi));
        if (lvl && i == 0)
            extReqPinZero <= 1'h1;
        if (lvl && i == 2)
            extReqPinOne <= 1'h1;
        if (i == 4)
            serialReq <= 1'h0;
        if (i == 5)
        begin
            vBlank <= 1'h0;
            hBlank <= 1'h0;
        end
        if (ret)
            ret1();
    endtask

    task automatic quiet();
        repeat (6)
        begin
            @(posedge clock);
            chk(16'(vecReq), 16'h0000);
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clock);
        srst <= 1'h0;
        foreach (regs[k])
            rdChk(regs[k], 8'h00);
        wb(1'h1, 18'h00020, 8'hFF);
        rdChk(18'h00020, 8'h00);
        wb(1'h1, ADDR_IRQ_ENABLE, 8'hBF);
        for (int k = 0; k < 4; k++)
        begin
            pr = (k == 0) ? 6'h00 : rnd[5:0];
            wb(1'h1, ADDR_IRQ_PRIO, {2'h0, pr});
            callDelay <= {1'h1, rnd[6]};
            expQ = {};
            for (int h = 1; h >= 0; h--)
                for (int i = 0; i < 6; i++)
                    if (pr[i] == h)
                        expQ.push_back(i);
            fire(6'h3F);
            foreach (expQ[j])
                svc(expQ[j], pr[expQ[j]], 1'b1);
            rnd = lfsr(rnd);
        end
        callDelay <= 2'h0;
        wb(1'h1, ADDR_IRQ_PRIO, 8'h03);
        fire(6'h08);
        svc(3, 1'h0, 1'b0);
        rdChk(ADDR_IN_SERVICE, 8'h01);
        fire(6'h10);
        quiet();
        fire(6'h02);
        svc(1, 1'h1, 1'b0);
        rdChk(ADDR_IN_SERVICE, 8'h03);
        fire(6'h01);
        quiet();
        ret1();
        svc(0, 1'h1, 1'b1);
        ret1();
        svc(4, 1'h0, 1'b1);
        rdChk(ADDR_IN_SERVICE, 8'h00);
        wb(1'h1, ADDR_IRQ_PRIO, 8'h00);
        wb(1'h1, ADDR_EVT_CLEAR, 8'h3F);
        wb(1'h1, ADDR_IRQ_ENABLE, 8'h3F);
        fire(6'h02);
        quiet();
        rdChk(ADDR_EVT_STATUS, 8'h02);
        for (int k = 0; k < 3; k++)
        begin
            wb(1'h1, k == 2 ? ADDR_EVT_CLEAR : ADDR_EVT_ENABLE, k == 1 ? 8'h00 : 8'h02);
            @(posedge clock);
            chk(16'(irqOut), 16'(k == 0));
        end
        rdChk(ADDR_EVT_STATUS, 8'h00);
        wb(1'h1, ADDR_IRQ_ENABLE, 8'hBD);
        quiet();
        wb(1'h1, ADDR_IRQ_ENABLE, 8'hBF);
        svc(1, 1'h0, 1'b1);
        lvl = 1'h0;
        wb(1'h1, ADDR_TIMER_CTRL, 8'h05);
        fire(6'h01);
        svc(0, 1'h0, 1'b1);
        extReqPinZero <= 1'h1;
        quiet();
        fire(6'h04);
        svc(2, 1'h0, 1'b1);
        extReqPinOne <= 1'h1;
        svc(2, 1'h0, 1'b1);
        wb(1'h1, ADDR_DISP_CFG, 8'h01);
        lineActive <= 1'h1;
        hBlank     <= 1'h1;
        svc(5, 1'h0, 1'b1);
        lineActive <= 1'h0;
        hBlank     <= 1'h1;
        quiet();
        vBlank <= 1'h1;
        quiet();
        closeOut();
    end
endmodule

// file: testbench/tlic_checker.sv
// Purpose: Port assertions for the interrupt controller.
// Assumes: Shadows follow accepted bus writes and core calls.
// Notes:   Attached to tlic_core by bind.
`timescale 1ns/100ps

module tlic_checker
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic             clock,
    input wire logic             srst,
    // Bus
    input wire logic             wbCyc,
    input wire logic             wbStb,
    input wire logic             wbWe,
    input wire logic [WB_AW-1:0] wbAdr,
    input wire logic [3:0]       wbSel,
    input wire logic [WB_DW-1:0] wbDatI,
    input wire logic             wbAck,
    // Core
    input wire logic             callTaken,
    input wire logic             retiPulse,
    input wire logic             vecReq,
    input wire logic [VEC_W-1:0] vecAddr,
    input wire logic             vecHighLevel
);
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] pr;
        logic       hi;
        logic       lo;
    } tlic_shadow_t;

    tlic_shadow_t sh_q, sh_d;
    logic         wr;
    logic [2:0]   vIdx;

    assign wr   = wbCyc && wbStb && !wbAck && wbWe && wbSel[0];
    // Vectors skip one slot below the serial entry.
    assign vIdx = vecAddr[5:3] - {2'h0, vecAddr[5]};

    always_comb
    begin
        sh_d = sh_q;
        if (wr && wbAdr == ADDR_IRQ_ENABLE)
            sh_d.en = wbDatI[7:0];
        if (wr && wbAdr == ADDR_IRQ_PRIO)
            sh_d.pr = wbDatI[7:0];
        if (vecReq && callTaken)
        begin
            sh_d.hi = sh_q.hi | vecHighLevel;
            sh_d.lo = sh_q.lo | !vecHighLevel;
        end
        if (retiPulse)
        begin
            sh_d.hi = 1'h0;
            sh_d.lo = sh_q.lo & sh_q.hi;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            sh_q <= '0;
        else
            sh_q <= sh_d;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_ack_next; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_once; wbAck |=> !wbAck; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_vec_set;
        vecReq |-> vecAddr inside {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h002B, 16'h0033};
    endproperty
    a_vec_set: assert property (p_vec_set) else $error("bad vector");
    property p_call_drop; vecReq && callTaken |=> !vecReq; endproperty
    a_call_drop: assert property (p_call_drop) else $error("offer kept after call");
    property p_glob_off; !sh_q.en[7] |=> !vecReq; endproperty
    a_glob_off: assert property (p_glob_off) else $error("offer while disabled");
    property p_level; vecReq && callTaken |-> vecHighLevel == sh_q.pr[vIdx]; endproperty
    a_level: assert property (p_level) else $error("wrong offered level");
    property p_hi_block; sh_q.hi |-> !vecReq; endproperty
    a_hi_block: assert property (p_hi_block) else $error("high routine preempted");
    property p_lo_block; sh_q.lo && vecReq |-> vecHighLevel; endproperty
    a_lo_block: assert property (p_lo_block) else $error("low routine preempted by low");
endmodule

bind tlic_core tlic_checker tlic_checker_inst (.clock, .srst, .wbCyc, .wbStb, .wbWe,
    .wbAdr, .wbSel, .wbDatI, .wbAck, .callTaken, .retiPulse, .vecReq, .vecAddr,
    .vecHighLevel);

// file: testbench/tlic_cpu_model.sv
// Purpose: Processor core model that takes vector calls and returns.
// Assumes: The bench sets the call delay and asks for each return.
// Notes:   Calls only while an offer stands, as a real core does.
`timescale 1ns/100ps

module tlic_cpu_model
    import tlic_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // Controller side
    input  wire logic             vecReq,
    output logic                  callTaken,
    output logic                  retiPulse,
    // Bench side
    input  wire logic [1:0]       callDelay,
    input  wire logic             retGo
);
    logic [1:0] wait_q;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wait_q    <= 2'h0;
            callTaken <= 1'h0;
            retiPulse <= 1'h0;
        end
        else
        begin
            callTaken <= 1'h0;
            retiPulse <= retGo;
            wait_q    <= 2'h0;
            // A slow core gives a standing offer time to be withdrawn.
            if (vecReq && !callTaken && wait_q == callDelay)
                callTaken <= 1'h1;
            else if (vecReq && !callTaken)
                wait_q <= wait_q + 2'h1;
        end
    end
endmodule
